// >>> sflash_cfg.v
// configuration register pair of a serial flash, with command port
// assumes serial clock mode 0, commands on one input line, msb first,
// serial clock well below half of clk_sys
`timescale 1ns/100ps
`include "sflash_cfg_regs.vh"

module sflash_cfg #(
  parameter [7:0] OP_RD_PWR = 8'hb5,
  parameter [7:0] OP_WR_PWR = 8'hb1,
  parameter [7:0] OP_RD_RUN = 8'h85,
  parameter [7:0] OP_WR_RUN = 8'h81
) (
  input wire clk_sys,
  input wire resetn,
  input wire porn,
  input wire csN,
  input wire sclk,
  input wire mosi,
  output reg miso,
  output reg misoOeN,
  input wire readStart,
  input wire [31:0] startAddr,
  input wire byteAdvance,
  output reg [26:0] curAddr,
  output reg [3:0] dummyCycles,
  output reg xipEnable,
  output reg [2:0] xipMode,
  output reg [2:0] driveCode,
  output reg dtrEnable,
  output reg holdResetEnable,
  output reg quadProtocol,
  output reg dualProtocol,
  output reg [2:0] extAddrSel,
  output reg fourByteAddr,
  output reg [1:0] wrapSize
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CMD = 3'h1;
  localparam [2:0] ST_WDATA = 3'h2;
  localparam [2:0] ST_RDATA = 3'h3;
  localparam [2:0] ST_SKIP = 3'h4;

  wire csSync;
  wire sclkSync;
  wire mosiSync;
  reg sclkPrev;
  wire sclkRise;
  wire sclkFall;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [7:0] cmd;
  reg [4:0] bitCnt;
  reg [15:0] inShift;
  reg [15:0] outShift;

  reg [15:0] pwrCfg;
  reg [7:0] runCfg;
  reg pwrCommit;
  reg runCommit;
  wire [15:0] pwrWord;
  wire [7:0] runWord;
  wire [15:0] loadSrc;
  wire [7:0] cmdByte;
  wire sysRstN;

  // a power-on is a reset as well, so no frame resumes across it
  assign sysRstN = resetn & porn;

  // pin inputs pass two flops; chip select idles high
  sync_two_ff #(
    .W(3),
    .INIT(3'b001)
  ) u_pinSync (
    .clk_sys(clk_sys),
    .resetn(sysRstN),
    .async({sclk, mosi, csN}),
    .synced({sclkSync, mosiSync, csSync})
  );

  // serial clock edges found on the synchronised copy only
  // both edges lag the pin by two clocks, so sclk must stay slow
  always @(posedge clk_sys) begin
    if (!sysRstN) begin
      sclkPrev <= 1'b0;
    end else begin
      sclkPrev <= sclkSync;
    end
  end

  assign sclkRise = sclkSync & ~sclkPrev;
  assign sclkFall = ~sclkSync & sclkPrev;

  // command byte as it stands once the eighth bit is shifted in
  assign cmdByte = {cmd[6:0], mosiSync};

  // data arrives low byte first, msb first within each byte
  assign pwrWord = {inShift[7:0], inShift[15:8]};
  // reserved runtime bit always held at zero
  assign runWord = inShift[7:0] & 8'hfb;

  // next state of the command sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (!csSync) begin
          next_state = ST_CMD;
        end
      end
      ST_CMD: begin
        if (csSync) begin
          next_state = ST_IDLE;
        end else if (sclkRise && bitCnt == {1'b0, `CMD_BITS} - 5'h01) begin
          // only the dedicated commands reach the two registers
          if (cmdByte == OP_RD_PWR || cmdByte == OP_RD_RUN) begin
            next_state = ST_RDATA;
          end else if (cmdByte == OP_WR_PWR || cmdByte == OP_WR_RUN) begin
            next_state = ST_WDATA;
          end else begin
            next_state = ST_SKIP;
          end
        end
      end
      ST_WDATA: begin
        if (csSync) begin
          next_state = ST_IDLE;
        end
      end
      ST_RDATA: begin
        if (csSync) begin
          next_state = ST_IDLE;
        end
      end
      ST_SKIP: begin
        // unknown opcodes are ignored until deselect
        if (csSync) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // commit only an exact-length write, at deselect
  always @* begin
    pwrCommit = 1'b0;
    runCommit = 1'b0;
    if (state == ST_WDATA && csSync) begin
      if (cmd == OP_WR_PWR && bitCnt == `PWR_DATA_BITS) begin
        pwrCommit = 1'b1;
      end
      if (cmd == OP_WR_RUN && bitCnt == `RUN_DATA_BITS) begin
        runCommit = 1'b1;
      end
    end
  end

  // sequencer state, command and bit counting
  always @(posedge clk_sys) begin
    if (!sysRstN) begin
      state <= ST_IDLE;
      cmd <= 8'h00;
      bitCnt <= 5'h00;
      inShift <= 16'h0000;
    end else begin
      state <= next_state;
      case (state)
        ST_IDLE: begin
          bitCnt <= 5'h00;
          inShift <= 16'h0000;
        end
        ST_CMD: begin
          if (sclkRise) begin
            cmd <= cmdByte;
            if (bitCnt == {1'b0, `CMD_BITS} - 5'h01) begin
              bitCnt <= 5'h00;
            end else begin
              bitCnt <= bitCnt + 5'h01;
            end
          end
        end
        ST_WDATA: begin
          if (sclkRise) begin
            inShift <= {inShift[14:0], mosiSync};
            // saturate so overlong frames never alias to a legal length
            if (bitCnt != 5'h1f) begin
              bitCnt <= bitCnt + 5'h01;
            end
          end
        end
        default: begin
          bitCnt <= bitCnt;
        end
      endcase
    end
  end

  // read data shifts out on falling edges and repeats while selected
  always @(posedge clk_sys) begin
    if (!sysRstN) begin
      outShift <= 16'h0000;
      miso <= 1'b0;
      misoOeN <= 1'b1;
    end else begin
      if (state == ST_CMD && next_state == ST_RDATA) begin
        if (cmdByte == OP_RD_PWR) begin
          outShift <= {pwrCfg[7:0], pwrCfg[15:8]};
        end else begin
          outShift <= {runCfg, runCfg};
        end
      end else if (state == ST_RDATA && sclkFall) begin
        miso <= outShift[15];
        outShift <= {outShift[14:0], outShift[15]};
      end
      // line is driven only during the read data phase
      misoOeN <= ~(next_state == ST_RDATA);
      // parked low when idle so a released line shows a known level
      if (next_state != ST_RDATA) begin
        miso <= 1'b0;
      end
    end
  end

  // trade-off: no write-enable gate, any exact-length frame commits
  // power-on register: kept across reset, set to all ones only at power-on
  always @(posedge clk_sys) begin
    if (!porn) begin
      pwrCfg <= `PWR_CFG_DEFAULT;
    end else if (pwrCommit) begin
      pwrCfg <= pwrWord;
    end
  end

  // at power-on the register itself is still settling to its default
  assign loadSrc = porn ? pwrCfg : `PWR_CFG_DEFAULT;

  // runtime register follows the power-on word at every reset
  always @(posedge clk_sys) begin
    if (!porn || !resetn) begin
      runCfg[`RUN_DUMMY_HI:`RUN_DUMMY_LO] <=
        loadSrc[`PWR_DUMMY_HI:`PWR_DUMMY_LO];
      runCfg[`RUN_XIP_BIT] <=
        (loadSrc[`PWR_XIP_HI:`PWR_XIP_LO] == `XIP_DISABLED);
      runCfg[`RUN_RSVD_BIT] <= 1'b0;
      runCfg[`RUN_WRAP_HI:`RUN_WRAP_LO] <= `WRAP_CONT;
    end else if (runCommit) begin
      runCfg <= runWord;
    end
  end

  // internal configuration: power-on word at reset, runtime on write
  always @(posedge clk_sys) begin
    if (!porn || !resetn) begin
      // zero in the dummy field counts as fifteen
      if (loadSrc[`PWR_DUMMY_HI:`PWR_DUMMY_LO] == 4'h0) begin
        dummyCycles <= 4'hf;
      end else begin
        dummyCycles <= loadSrc[`PWR_DUMMY_HI:`PWR_DUMMY_LO];
      end
      xipMode <= loadSrc[`PWR_XIP_HI:`PWR_XIP_LO];
      xipEnable <=
        (loadSrc[`PWR_XIP_HI:`PWR_XIP_LO] != `XIP_DISABLED);
      // reserved codes are passed through untouched
      driveCode <= loadSrc[`PWR_DRIVE_HI:`PWR_DRIVE_LO];
      dtrEnable <= ~loadSrc[`PWR_DTR_BIT];
      holdResetEnable <= loadSrc[`PWR_HOLD_BIT];
      quadProtocol <= ~loadSrc[`PWR_QUAD_BIT];
      // quad wins, so dual only shows when quad is off
      dualProtocol <= ~loadSrc[`PWR_DUAL_BIT] &
        loadSrc[`PWR_QUAD_BIT];
      fourByteAddr <= ~loadSrc[`PWR_ADDR_BIT];
      wrapSize <= `WRAP_CONT;
    end else if (runCommit) begin
      // applied straight away, no reset needed
      if (runWord[`RUN_DUMMY_HI:`RUN_DUMMY_LO] == 4'h0) begin
        dummyCycles <= 4'hf;
      end else begin
        dummyCycles <= runWord[`RUN_DUMMY_HI:`RUN_DUMMY_LO];
      end
      xipEnable <= ~runWord[`RUN_XIP_BIT];
      wrapSize <= runWord[`RUN_WRAP_HI:`RUN_WRAP_LO];
    end
  end

  // no command moves the segment; reads may cross it freely
  // segment select is only preset here, high or low segment
  always @(posedge clk_sys) begin
    if (!porn || !resetn) begin
      if (loadSrc[`PWR_SEG_BIT]) begin
        extAddrSel <= `SEG_LOWEST;
      end else begin
        extAddrSel <= `SEG_HIGHEST;
      end
    end
  end

  // limitation: the caller paces the walk; nothing here counts bytes
  // read address walker
  reg [26:0] firstAddr;
  reg [26:0] wrapMask;
  reg [26:0] stepAddr;

  // segment bits come from the select only in three-byte mode
  always @* begin
    if (fourByteAddr) begin
      firstAddr = startAddr[26:0];
    end else begin
      firstAddr = {extAddrSel, startAddr[23:0]};
    end
  end

  // aligned block size for each wrap setting
  // wrap masks apply in four-byte mode as well
  always @* begin
    case (wrapSize)
      `WRAP_16: wrapMask = 27'h000000f;
      `WRAP_32: wrapMask = 27'h000001f;
      `WRAP_64: wrapMask = 27'h000003f;
      default: wrapMask = 27'h7ffffff;
    endcase
  end

  // low bits roll within the block, high bits stay at its base
  always @* begin
    stepAddr = (curAddr & ~wrapMask) |
      ((curAddr + 27'h0000001) & wrapMask);
  end

  // continuous mode rolls over the whole array back to zero
  always @(posedge clk_sys) begin
    if (!sysRstN) begin
      curAddr <= 27'h0000000;
    end else if (readStart) begin
      curAddr <= firstAddr;
    end else if (byteAdvance) begin
      curAddr <= stepAddr;
    end
  end

endmodule // sflash_cfg

// >>> sflash_cfg_properties.sv
// port assertions for the config register pair
// assumes synchronous resets sampled by clk_sys
`timescale 1ns/100ps
module sflash_cfg_properties (
  input wire clk_sys,
  input wire resetn,
  input wire porn,
  input wire csN,
  input wire misoOeN,
  input wire readStart,
  input wire [31:0] startAddr,
  input wire byteAdvance,
  input wire [26:0] curAddr,
  input wire [3:0] dummyCycles,
  input wire xipEnable,
  input wire [2:0] xipMode,
  input wire quadProtocol,
  input wire dualProtocol,
  input wire [2:0] extAddrSel,
  input wire fourByteAddr,
  input wire [1:0] wrapSize
);
  reg [26:0] expAddr;
  wire [26:0] msk;
  // wrap keeps the high bits, steps only the low ones
  assign msk = wrapSize == 2'h3 ? 27'h7ffffff : (27'h10 << wrapSize) - 27'h1;
  // address the port should show one edge later
  always @(posedge clk_sys) begin
    if (readStart)
      expAddr <= fourByteAddr ? startAddr[26:0] :
        {extAddrSel, startAddr[23:0]};
    else
      expAddr <= (curAddr & ~msk) | ((curAddr + 27'h1) & msk);
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  AST_START: assert property (readStart |=> curAddr == expAddr)
    else $error("start address wrong");
  AST_WRAP: assert property (
    byteAdvance && !readStart |=> curAddr == expAddr)
    else $error("address step wrong");
  AST_POR: assert property ($rose(porn) |-> dummyCycles == 4'hf &&
    !xipEnable && xipMode == 3'h7 && !quadProtocol && !dualProtocol &&
    extAddrSel == 3'h0 && !fourByteAddr && wrapSize == 2'h3)
    else $error("power-on defaults wrong");
  AST_RST: assert property ($rose(resetn) |-> misoOeN &&
    xipEnable == (xipMode != 3'h7) && wrapSize == 2'h3)
    else $error("reload after reset wrong");
  AST_QUAD: assert property (quadProtocol |-> !dualProtocol)
    else $error("quad and dual both on");
  AST_DUMMY: assert property (dummyCycles != 4'h0)
    else $error("zero dummy count shown");
  AST_SEG: assert property (
    $changed(extAddrSel) |-> !$past(resetn) || !$past(porn))
    else $error("segment changed outside reset");
  AST_OE: assert property (csN [*6] |-> misoOeN)
    else $error("output enabled while deselected");
  AST_STABLE: assert property ((csN && porn) [*8] |=>
    $stable(dummyCycles) && $stable(wrapSize) && $stable(xipEnable))
    else $error("config changed while idle");
endmodule // sflash_cfg_properties

bind sflash_cfg sflash_cfg_properties u_props (.*);

// >>> sflash_cfg_regs.vh
// constants for the serial flash configuration register pair
// assumes a single-line serial command port sampled by a 100 MHz clock
`ifndef SFLASH_CFG_REGS_VH
`define SFLASH_CFG_REGS_VH

// reset values
`define PWR_CFG_DEFAULT 16'hffff
`define RUN_CFG_DEFAULT 8'hfb

// power-on config field positions
`define PWR_DUMMY_HI 15
`define PWR_DUMMY_LO 12
`define PWR_XIP_HI 11
`define PWR_XIP_LO 9
`define PWR_DRIVE_HI 8
`define PWR_DRIVE_LO 6
`define PWR_DTR_BIT 5
`define PWR_HOLD_BIT 4
`define PWR_QUAD_BIT 3
`define PWR_DUAL_BIT 2
`define PWR_SEG_BIT 1
`define PWR_ADDR_BIT 0

// runtime config field positions
`define RUN_DUMMY_HI 7
`define RUN_DUMMY_LO 4
`define RUN_XIP_BIT 3
`define RUN_RSVD_BIT 2
`define RUN_WRAP_HI 1
`define RUN_WRAP_LO 0

// encodings
`define XIP_DISABLED 3'h7
`define WRAP_16 2'h0
`define WRAP_32 2'h1
`define WRAP_64 2'h2
`define WRAP_CONT 2'h3
`define SEG_LOWEST 3'h0
`define SEG_HIGHEST 3'h7

// command frame lengths in serial clocks
`define CMD_BITS 4'h8
`define PWR_DATA_BITS 5'h10
`define RUN_DATA_BITS 5'h08

`endif

// >>> sflash_cfg_test.sv
// self-checking bench for the config register pair
// assumes the host model drives the serial port
`timescale 1ns/100ps
module sflash_cfg_test;
  reg clk_sys = 1'b0;
  reg resetn = 1'b0;
  reg porn = 1'b0;
  reg readStart = 1'b0;
  reg byteAdvance = 1'b0;
  reg [31:0] startAddr = 32'h0;
  reg [15:0] cur = 16'hffff;
  wire csN, sclk, mosi, miso, misoOeN, xipEnable, dtrEnable;
  wire holdResetEnable, quadProtocol, dualProtocol, fourByteAddr;
  wire [26:0] curAddr;
  wire [3:0] dummyCycles;
  wire [2:0] xipMode, driveCode, extAddrSel;
  wire [1:0] wrapSize;
  wire [18:0] obs;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  sflash_cfg u_dut (.*);
  sflash_host u_host (.*);
  assign obs = {dummyCycles, xipEnable, xipMode, driveCode, dtrEnable,
    holdResetEnable, quadProtocol, dualProtocol, extAddrSel, fourByteAddr};
  always #5 clk_sys = ~clk_sys;
  // decoded outputs after a reload from power-on word p
  function [18:0] dec(input [15:0] p);
    dec = {p[15:12] == 4'h0 ? 4'hf : p[15:12], p[11:9] != 3'h7, p[11:9],
      p[8:6], ~p[5], p[4], ~p[3], p[3] & ~p[2], p[1] ? 3'h0 : 3'h7, ~p[0]};
  endfunction
  function [26:0] step(input [26:0] a, input [1:0] w);
    reg [26:0] m;
    m = w == 2'h3 ? 27'h7ffffff : (27'h10 << w) - 27'h1;
    step = (a & ~m) | ((a + 27'h1) & m);
  endfunction
  task automatic chk(input [26:0] got, input [26:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rst(input bit pw);
    if (pw)
      porn <= 1'b0;
    else
      resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    porn <= 1'b1;
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  // write the power-on word; it only takes effect at the next reset
  task automatic setp(input [15:0] p);
    reg [15:0] r;
    u_host.xfer(u_dut.OP_WR_PWR, p, 16, r);
    chk(obs, dec(cur));
    rst(1'b0);
    cur = p;
    chk(obs, dec(p));
    chk(wrapSize, 2'h3);
    u_host.xfer(u_dut.OP_RD_PWR, 16'h0, 16, r);
    chk(r, p);
    u_host.xfer(u_dut.OP_RD_RUN, 16'h0, 8, r);
    chk(r[7:0], {p[15:12], p[11:9] == 3'h7, 3'h3});
  endtask
  // load an address, then step it every cycle under wrap code w
  task automatic walk(input [1:0] w);
    reg [26:0] a;
    reg [15:0] r;
    u_host.xfer(u_dut.OP_WR_RUN, {8'h0, 6'h24, w}, 8, r);
    startAddr <= $urandom;
    readStart <= 1'b1;
    @(posedge clk_sys);
    readStart <= 1'b0;
    byteAdvance <= 1'b1;
    a = cur[0] ? {cur[1] ? 3'h0 : 3'h7, startAddr[23:0]} : startAddr[26:0];
    #1 chk(curAddr, a);
    repeat (70) begin
      @(posedge clk_sys);
      #1 a = step(a, w);
      chk(curAddr, a);
    end
    @(posedge clk_sys);
    byteAdvance <= 1'b0;
  endtask
  // hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      wrap_up;
    end
  end
  initial begin : main
    reg [15:0] r;
    reg [15:0] p;
    reg [7:0] v;
    int i, w;
    void'($urandom(53162));
    repeat (3) @(posedge clk_sys);
    porn <= 1'b1;
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(obs, dec(16'hffff));
    // runtime writes: all-zero corner, then random bytes
    for (i = 0; i < 8; i++) begin
      v = i == 0 ? 8'h00 : 8'($urandom);
      u_host.xfer(u_dut.OP_WR_RUN, {8'h0, v}, 8, r);
      chk({dummyCycles, xipEnable, wrapSize},
        {v[7:4] == 4'h0 ? 4'hf : v[7:4], ~v[3], v[1:0]});
      u_host.xfer(u_dut.OP_RD_RUN, 16'h0, 8, r);
      chk(r[7:0], v & 8'hfb);
    end
    // a short write frame must be dropped
    u_host.xfer(u_dut.OP_WR_RUN, 16'h00aa, 7, r);
    u_host.xfer(u_dut.OP_RD_RUN, 16'h0, 8, r);
    chk(r[7:0], v & 8'hfb);
    rst(1'b1);
    chk(obs, dec(16'hffff));
    for (i = 0; i < 6; i++) begin
      p = 16'($urandom);
      w = $urandom % 6;
      p[11:6] = {w == 5 ? 3'h7 : 3'(w), 2'($urandom), 1'b1};
      if (i == 0)
        p = 16'h0040;
      setp(p);
    end
    setp(16'hfffd);
    for (w = 0; w < 4; w++)
      walk(2'(w));
    // the walks rewrote the runtime word; a reset restores it
    rst(1'b0);
    chk(obs, dec(16'hfffd));
    setp(16'hfffe);
    for (w = 0; w < 4; w++)
      walk(2'(w));
    wrap_up;
  end
endmodule // sflash_cfg_test

// >>> sflash_host.sv
// host model of the serial command port, mode 0, msb first
// assumes clk_sys 100 MHz; serial clock period is 8 clk_sys
`timescale 1ns/100ps
module sflash_host (
  input wire clk_sys,
  input wire miso,
  input wire misoOeN,
  output reg csN,
  output reg sclk,
  output reg mosi
);
  // idle: deselected, clock parked low
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // opcode then n data bits, low byte first, msb first in each byte
  task automatic xfer(input [7:0] op, input [15:0] wd, input int n,
      output [15:0] rd);
    int i, k;
    rd = 16'h0;
    csN <= 1'b0;
    tick(4);
    for (i = 0; i < 8 + n; i++) begin
      k = i < 16 ? 15 - i : 31 - i;
      if (i < 8)
        mosi <= op[7 - i];
      else
        mosi <= wd[k];
      tick(4);
      sclk <= 1'b1;
      tick(4);
      if (i >= 8)
        rd[k] = misoOeN ? 1'bx : miso; // undriven line reads unknown
      sclk <= 1'b0;
    end
    tick(4);
    csN <= 1'b1;
    mosi <= ~mosi; // released line must not keep its value
    tick(10);
  endtask
endmodule // sflash_host

// >>> sync_two_ff.v
// two-flop synchroniser for a group of independent level signals
// assumes each bit is an unrelated level; no bus coherence implied
`timescale 1ns/100ps

module sync_two_ff #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk_sys,
  input wire resetn,
  input wire [W-1:0] async,
  output reg [W-1:0] synced
);

  reg [W-1:0] stage1;

  // first stage is read only by the second stage
  always @(posedge clk_sys) begin
    if (!resetn) begin
      stage1 <= INIT;
      synced <= INIT;
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end

endmodule // sync_two_ff
